// ---- verilog/spc_pkg.sv ----
// package with register map, field layout and types for the shutdown pin block
package spc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CFG_W = 16;
    // register byte offsets
    localparam logic [3:0] OFF_PACK_CFG = 4'h0;
    localparam logic [3:0] OFF_CONTROL = 4'h4;
    localparam logic [3:0] OFF_POWER_STATE = 4'h8;
    localparam logic [3:0] OFF_NV_LOCATION = 4'hc;
    // control subcommands
    localparam logic [15:0] CMD_ARM = 16'h0013;
    localparam logic [15:0] CMD_DISARM = 16'h0014;
    // control status bit positions
    localparam int STAT_PIN_ACTIVE = 15;
    localparam int STAT_ARMED = 7;
    // nonvolatile location of the configuration word
    localparam logic [7:0] NV_SUBCLASS = 8'h40;
    localparam logic [7:0] NV_OFFSET = 8'h00;
    localparam int NV_SUBCLASS_POS = 8;
    // reset values
    localparam logic [15:0] PACK_CFG_RESET = 16'h0177;
    localparam logic ARMED_RESET = 1'b1;
    localparam logic PIN_ACTIVE_RESET = 1'b0;

    typedef struct packed {
        logic spareCapacityNoloadComp;
        logic [2:0] unusedHigh;
        logic adcGroundChoice;
        logic wakeCurrentLevel;
        logic currentRangeHi;
        logic currentRangeLo;
        logic unusedLow;
        logic resistanceFactorStepping;
        logic sleepEnable;
        logic capacityFillOnTerm;
        logic pinDrivePullup;
        logic pinPolarityChoice;
        logic powerOffFeatureEnable;
        logic thermistorChoice;
    } spc_cfg_type;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_SLEEP,
        PWR_HIBERNATE
    } spc_power_type;

    typedef struct packed {
        logic level;
        logic oeN;
    } spc_pin_type;

    localparam spc_pin_type PIN_HIZ = '{level: 1'b0, oeN: 1'b1};
    localparam spc_pin_type PIN_LOW = '{level: 1'b0, oeN: 1'b0};
    localparam spc_pin_type PIN_HIGH = '{level: 1'b1, oeN: 1'b0};
endpackage : spc_pkg

// ---- verilog/spc_shutdown_pin.sv ----
// power-off pin control, pack configuration word and power state logic
//
// Operation
// - control status bit 15 shows the power-off pin is active, zero after reset
// - control status bit 7 holds the armed flag, one after reset
// - subcommand 0x0013 sets the armed flag
// - subcommand 0x0014 clears the armed flag
// - writing the feature enable bit set also sets the armed flag
// - pin goes to shutdown state only while hibernating and armed
// - pin levels per pull-up and polarity, normal then shutdown state
// - pin is high impedance during power-on reset regardless of polarity
// - pull-up change takes effect only after the next power-on reset; the code reloads the default at reset, so the pin stays open-drain
// - configuration word lives in nonvolatile subclass 64 at offset zero
// - configuration word bit layout of high and low bytes
// - spare capacity bit selects no-load compensation, default zero
// - ground choice bit picks main or alternate ground, default zero
// - wake level and current range bits set wake, defaults 0/0/1
// - resistance stepping bit enables factor stepping, default one
// - sleep enable bit allows sleep state, default one
// - capacity fill bit loads full capacity on termination, default one
// - pull-up bit at low bit 3 makes the pin push-pull, default zero
// - polarity bit clear means low at shutdown, set means high, default one
// - feature enable bit shows shutdown feature enabled, default one
// - thermistor bit selects external thermistor, default one
// - hibernate is a very low power state from low voltage or low current
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
module spc_shutdown_pin (
    input wire logic clk,
    input wire logic reset,
    input wire logic [spc_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [spc_pkg::DATA_W-1:0] writedata,
    output logic [spc_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic lowCellVoltage,
    input wire logic lowLoadCurrent,
    input wire logic sleepCondition,
    input wire logic wakeEvent,
    output spc_pkg::spc_power_type powerState,
    output logic powerOffPinOut,
    output logic powerOffPinOeN,
    output logic spareCapacityNoloadComp,
    output logic adcGroundChoice,
    output logic wakeCurrentLevel,
    output logic [1:0] currentRange,
    output logic resistanceFactorStepping,
    output logic sleepEnable,
    output logic capacityFillOnTerm,
    output logic thermistorChoice
);
    spc_pkg::spc_cfg_type cfg;
    spc_pkg::spc_pin_type pin;
    spc_pkg::spc_pin_type next_pin;
    spc_pkg::spc_power_type next_powerState;
    logic armed;
    logic pinActive;
    logic pullupLatched;
    logic loadPending;
    logic ackDone;
    logic busReq;
    logic accept;
    logic cfgWrite;
    logic ctrlWrite;
    logic shutdownReq;
    logic [15:0] ctrlStatus;
    logic [spc_pkg::DATA_W-1:0] next_readdata;

    // bus handshake: one wait cycle, then the answer
    assign busReq = read | write;
    assign waitrequest = busReq & ~ackDone;
    assign accept = busReq & ackDone;
    assign cfgWrite = accept & write & (address == spc_pkg::OFF_PACK_CFG);
    assign ctrlWrite = accept & write & (address == spc_pkg::OFF_CONTROL);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ackDone <= 1'b0;
        end else begin
            ackDone <= busReq & ~ackDone;
        end
    end

    always_comb begin
        ctrlStatus = 16'h0000;
        ctrlStatus[spc_pkg::STAT_PIN_ACTIVE] = pinActive;
        ctrlStatus[spc_pkg::STAT_ARMED] = armed;
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (address)
            spc_pkg::OFF_PACK_CFG: next_readdata[spc_pkg::CFG_W-1:0] = cfg;
            spc_pkg::OFF_CONTROL: next_readdata[15:0] = ctrlStatus;
            spc_pkg::OFF_POWER_STATE: next_readdata[1:0] = powerState;
            spc_pkg::OFF_NV_LOCATION: next_readdata[15:0] =
                {spc_pkg::NV_SUBCLASS, spc_pkg::NV_OFFSET};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (read & ~ackDone) begin
            readdata <= next_readdata;
        end
    end

    // configuration loaded with its stored defaults at reset
    // field layout fixed by the packed struct
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg <= spc_pkg::PACK_CFG_RESET;
        end else if (cfgWrite) begin
            cfg <= writedata[spc_pkg::CFG_W-1:0];
            cfg.unusedHigh <= 3'h0;
            cfg.unusedLow <= 1'b0;
        end
    end

    // pull-up sampled once after reset release only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loadPending <= 1'b1;
            pullupLatched <= 1'b0;
        end else if (loadPending) begin
            loadPending <= 1'b0;
            pullupLatched <= cfg.pinDrivePullup;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            armed <= spc_pkg::ARMED_RESET;
        end else if ((ctrlWrite && writedata[15:0] == spc_pkg::CMD_ARM) ||
                     (cfgWrite && writedata[1])) begin
            // enable bit written set marks the feature on
            armed <= 1'b1;
        end else if (ctrlWrite && writedata[15:0] == spc_pkg::CMD_DISARM) begin
            armed <= 1'b0;
        end
    end

    always_comb begin
        next_powerState = powerState;
        unique case (powerState)
            spc_pkg::PWR_NORMAL, spc_pkg::PWR_SLEEP: begin
                if (lowCellVoltage | lowLoadCurrent) begin
                    next_powerState = spc_pkg::PWR_HIBERNATE;
                end else if (cfg.sleepEnable & sleepCondition) begin
                    next_powerState = spc_pkg::PWR_SLEEP;
                end else begin
                    next_powerState = spc_pkg::PWR_NORMAL;
                end
            end
            spc_pkg::PWR_HIBERNATE: begin
                if (wakeEvent) begin
                    next_powerState = spc_pkg::PWR_NORMAL;
                end
            end
            default: next_powerState = spc_pkg::PWR_NORMAL;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            powerState <= spc_pkg::PWR_NORMAL;
        end else begin
            powerState <= next_powerState;
        end
    end

    // shutdown only in hibernate while armed
    assign shutdownReq = (powerState == spc_pkg::PWR_HIBERNATE) & armed;

    always_comb begin
        next_pin = spc_pkg::PIN_HIZ;
        unique case ({pullupLatched, cfg.pinPolarityChoice})
            2'b00: next_pin = shutdownReq ? spc_pkg::PIN_LOW : spc_pkg::PIN_HIZ;
            2'b01: next_pin = shutdownReq ? spc_pkg::PIN_HIZ : spc_pkg::PIN_LOW;
            2'b10: next_pin = shutdownReq ? spc_pkg::PIN_LOW : spc_pkg::PIN_HIGH;
            2'b11: next_pin = shutdownReq ? spc_pkg::PIN_HIGH : spc_pkg::PIN_LOW;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin <= spc_pkg::PIN_HIZ;
            pinActive <= spc_pkg::PIN_ACTIVE_RESET;
        end else begin
            pin <= next_pin;
            pinActive <= shutdownReq;
        end
    end

    assign powerOffPinOut = pin.level;
    assign powerOffPinOeN = pin.oeN;

    assign spareCapacityNoloadComp = cfg.spareCapacityNoloadComp;
    assign adcGroundChoice = cfg.adcGroundChoice;
    assign wakeCurrentLevel = cfg.wakeCurrentLevel;
    assign currentRange = {cfg.currentRangeHi, cfg.currentRangeLo};
    assign resistanceFactorStepping = cfg.resistanceFactorStepping;
    assign sleepEnable = cfg.sleepEnable;
    assign capacityFillOnTerm = cfg.capacityFillOnTerm;
    assign thermistorChoice = cfg.thermistorChoice;

    // checks

    a_pin_reset_hiz: assert property (
        @(posedge clk) $fell(reset) |-> pin.oeN)
        else $error("pin not high impedance right after reset");

    a_reset_defaults: assert property (
        @(posedge clk) $fell(reset) |-> cfg == spc_pkg::PACK_CFG_RESET && armed && !pinActive)
        else $error("state after reset differs from defaults");

    a_status_pin_active: assert property (
        @(posedge clk) disable iff (reset)
        ctrlStatus[spc_pkg::STAT_PIN_ACTIVE] == pinActive
        && ctrlStatus[spc_pkg::STAT_ARMED] == armed
        && (pinActive == $past(shutdownReq)))
        else $error("status bits do not follow shutdown state");

    a_armed_held: assert property (
        @(posedge clk) disable iff (reset)
        !ctrlWrite && !cfgWrite |=> $stable(armed))
        else $error("armed flag changed without a write");

    a_arm_subcmd: assert property (
        @(posedge clk) disable iff (reset)
        ctrlWrite && writedata[15:0] == spc_pkg::CMD_ARM |=> armed)
        else $error("arm subcommand did not set armed flag");

    a_disarm_subcmd: assert property (
        @(posedge clk) disable iff (reset)
        ctrlWrite && writedata[15:0] == spc_pkg::CMD_DISARM |=> !armed)
        else $error("disarm subcommand did not clear armed flag");

    a_enable_arms: assert property (
        @(posedge clk) disable iff (reset)
        cfgWrite && writedata[1] |=> armed && cfg.powerOffFeatureEnable)
        else $error("feature enable write did not arm");

    a_enable_bit: assert property (
        @(posedge clk) disable iff (reset)
        cfgWrite |=> cfg.powerOffFeatureEnable == $past(writedata[1]))
        else $error("feature enable bit not stored");

    a_shutdown_hibernate: assert property (
        @(posedge clk) disable iff (reset)
        powerState != spc_pkg::PWR_HIBERNATE || !armed |=> !pinActive)
        else $error("pin active outside armed hibernate");

    a_disarm_release: assert property (
        @(posedge clk) disable iff (reset)
        !armed |=> !pinActive && pin == $past(next_pin))
        else $error("disarmed pin still in shutdown");

    // pin table, one check per pull-up, polarity and state
    a_pin_norm_00: assert property (
        @(posedge clk) disable iff (reset)
        !pullupLatched && !cfg.pinPolarityChoice && !shutdownReq |=> pin == spc_pkg::PIN_HIZ)
        else $error("open-drain low polarity normal level wrong");

    a_pin_shut_00: assert property (
        @(posedge clk) disable iff (reset)
        !pullupLatched && !cfg.pinPolarityChoice && shutdownReq |=> pin == spc_pkg::PIN_LOW)
        else $error("open-drain low polarity shutdown level wrong");

    a_pin_norm_01: assert property (
        @(posedge clk) disable iff (reset)
        !pullupLatched && cfg.pinPolarityChoice && !shutdownReq |=> pin == spc_pkg::PIN_LOW)
        else $error("open-drain high polarity normal level wrong");

    a_pin_shut_01: assert property (
        @(posedge clk) disable iff (reset)
        !pullupLatched && cfg.pinPolarityChoice && shutdownReq |=> pin == spc_pkg::PIN_HIZ)
        else $error("open-drain high polarity shutdown level wrong");

    a_pin_norm_10: assert property (
        @(posedge clk) disable iff (reset)
        pullupLatched && !cfg.pinPolarityChoice && !shutdownReq |=> pin == spc_pkg::PIN_HIGH)
        else $error("push-pull low polarity normal level wrong");

    a_pin_shut_10: assert property (
        @(posedge clk) disable iff (reset)
        pullupLatched && !cfg.pinPolarityChoice && shutdownReq |=> pin == spc_pkg::PIN_LOW)
        else $error("push-pull low polarity shutdown level wrong");

    a_pin_norm_11: assert property (
        @(posedge clk) disable iff (reset)
        pullupLatched && cfg.pinPolarityChoice && !shutdownReq |=> pin == spc_pkg::PIN_LOW)
        else $error("push-pull high polarity normal level wrong");

    a_pin_table: assert property (
        @(posedge clk) disable iff (reset)
        !loadPending && pullupLatched && cfg.pinPolarityChoice && shutdownReq
        |=> pin == spc_pkg::PIN_HIGH)
        else $error("push-pull high polarity shutdown level wrong");

    a_pullup_load: assert property (
        @(posedge clk) disable iff (reset)
        loadPending |=> pullupLatched == $past(cfg.pinDrivePullup))
        else $error("pull-up not latched after reset");

    a_pullup_held: assert property (
        @(posedge clk) disable iff (reset)
        !loadPending |=> $stable(pullupLatched))
        else $error("pull-up selection changed without reset");

    a_cfg_write_lands: assert property (
        @(posedge clk) disable iff (reset)
        cfgWrite |=> cfg == ($past(writedata[15:0]) & 16'h8f7f))
        else $error("configuration write not stored as laid out");

    a_unused_zero: assert property (
        @(posedge clk) disable iff (reset)
        cfg.unusedHigh == 3'h0 && !cfg.unusedLow)
        else $error("unused configuration bits not zero");

    a_cfg_held: assert property (
        @(posedge clk) disable iff (reset)
        !cfgWrite |=> $stable(cfg))
        else $error("configuration changed without a write");

    a_hibernate_entry: assert property (
        @(posedge clk) disable iff (reset)
        powerState != spc_pkg::PWR_HIBERNATE && (lowCellVoltage || lowLoadCurrent)
        |=> powerState == spc_pkg::PWR_HIBERNATE)
        else $error("hibernate not entered on low voltage or current");

    a_hibernate_held: assert property (
        @(posedge clk) disable iff (reset)
        powerState == spc_pkg::PWR_HIBERNATE && !wakeEvent
        |=> powerState == spc_pkg::PWR_HIBERNATE)
        else $error("hibernate left without wake");

    a_wake_exit: assert property (
        @(posedge clk) disable iff (reset)
        powerState == spc_pkg::PWR_HIBERNATE && wakeEvent
        |=> powerState == spc_pkg::PWR_NORMAL)
        else $error("wake did not return to normal");

    a_sleep_gated: assert property (
        @(posedge clk) disable iff (reset)
        powerState == spc_pkg::PWR_NORMAL && !cfg.sleepEnable
        |=> powerState != spc_pkg::PWR_SLEEP)
        else $error("sleep entered while disabled");

    a_sleep_entry: assert property (
        @(posedge clk) disable iff (reset)
        powerState != spc_pkg::PWR_HIBERNATE && !lowCellVoltage && !lowLoadCurrent
        && cfg.sleepEnable && sleepCondition |=> powerState == spc_pkg::PWR_SLEEP)
        else $error("sleep not entered when allowed");

    a_sleep_exit: assert property (
        @(posedge clk) disable iff (reset)
        powerState == spc_pkg::PWR_SLEEP && !sleepCondition && !lowCellVoltage
        && !lowLoadCurrent |=> powerState == spc_pkg::PWR_NORMAL)
        else $error("sleep not left when condition ended");

    // bus handshake
    a_bus_answer: assert property (
        @(posedge clk) disable iff (reset)
        busReq && waitrequest |=> !waitrequest)
        else $error("bus answer later than one wait cycle");

    a_bus_wait_first: assert property (
        @(posedge clk) disable iff (reset)
        $rose(busReq) |-> waitrequest)
        else $error("bus answered without a wait cycle");

    a_read_data: assert property (
        @(posedge clk) disable iff (reset)
        accept && read |-> readdata == $past(next_readdata))
        else $error("read data not loaded in the wait cycle");

    a_read_upper_zero: assert property (
        @(posedge clk) disable iff (reset)
        accept && read |-> readdata[31:16] == 16'h0000)
        else $error("upper read data bits not zero");
endmodule : spc_shutdown_pin

// ---- tb/spc_poweroff_circuit.sv ----
// external power-off circuit watching the power-off line
`timescale 1ns/100ps
module spc_poweroff_circuit (
    input wire logic pinOut,
    input wire logic pinOeN,
    output logic lineLevel
);
    // a released line is pulled up by the circuit
    assign lineLevel = pinOeN ? 1'b1 : pinOut;
endmodule : spc_poweroff_circuit

// ---- tb/tb_spc_shutdown_pin.sv ----
// self-checking bench for the power-off pin block
`timescale 1ns/100ps
module tb_spc_shutdown_pin;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic lowCell = 1'b0;
    logic lowLoad = 1'b0;
    logic sleepCond = 1'b0;
    logic wake = 1'b0;
    spc_pkg::spc_power_type powerState;
    logic pinOut;
    logic pinOeN;
    logic lineLevel;
    logic [8:0] feat;
    spc_pkg::spc_pin_type pin;
    int mismatches = 0;
    int comparisons = 0;
    logic [31:0] d;
    logic [31:0] rnd;
    assign pin = {pinOut, pinOeN};
    always #4 clk = ~clk;
    spc_shutdown_pin spc_shutdown_pin_inst (.clk(clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .lowCellVoltage(lowCell), .lowLoadCurrent(lowLoad),
        .sleepCondition(sleepCond), .wakeEvent(wake), .powerState(powerState),
        .powerOffPinOut(pinOut), .powerOffPinOeN(pinOeN),
        .spareCapacityNoloadComp(feat[8]), .adcGroundChoice(feat[7]),
        .wakeCurrentLevel(feat[6]), .currentRange(feat[5:4]),
        .resistanceFactorStepping(feat[3]), .sleepEnable(feat[2]),
        .capacityFillOnTerm(feat[1]), .thermistorChoice(feat[0]));
    spc_poweroff_circuit spc_poweroff_circuit_inst (.pinOut(pinOut), .pinOeN(pinOeN),
        .lineLevel(lineLevel));
    task results;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task chkW(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkW
    task chkP(input spc_pkg::spc_pin_type got, input spc_pkg::spc_pin_type exp);
        chkW({30'h0, got}, {30'h0, exp});
    endtask : chkP
    // pin with pull-up latched clear: released when polarity equals shutdown
    function automatic spc_pkg::spc_pin_type pinExp(input logic pol, input logic shut);
        return (pol == shut) ? spc_pkg::PIN_HIZ : spc_pkg::PIN_LOW;
    endfunction : pinExp
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] v);
        int n;
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= v;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        d = readdata;
        if (n >= 50) begin
            mismatches++;
            results();
        end
        write <= 1'b0;
        read <= 1'b0;
        @(negedge clk);
    endtask : bus
    task rdChk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chkW(d, exp);
    endtask : rdChk
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    initial begin
        #200000;
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(32'h6402b8c0));
        @(negedge clk);
        chkP(pin, spc_pkg::PIN_HIZ);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rdChk(4'h0, 32'h0177);
        rdChk(4'h4, 32'h0080);
        rdChk(4'hc, 32'h4000);
        rdChk(4'h2, 32'h0);
        chkW({23'h0, feat}, 32'h0000001f);
        chkP(pin, pinExp(1'b1, 1'b0));
        @(posedge clk);
        lowCell <= 1'b1;
        cyc(3);
        @(posedge clk);
        lowCell <= 1'b0;
        cyc(1);
        chkP(pin, pinExp(1'b1, 1'b1));
        chkW({31'h0, lineLevel}, 32'h1);
        rdChk(4'h4, 32'h8080);
        bus(1'b1, 4'h0, 32'h0173);
        cyc(1);
        chkP(pin, pinExp(1'b0, 1'b1));
        bus(1'b1, 4'h4, 32'h0014);
        cyc(1);
        chkP(pin, pinExp(1'b0, 1'b0));
        rdChk(4'h4, 32'h0000);
        bus(1'b1, 4'h0, 32'h0179);
        cyc(1);
        chkP(pin, pinExp(1'b0, 1'b0));
        rdChk(4'h4, 32'h0000);
        bus(1'b1, 4'h4, 32'h0013);
        rdChk(4'h4, 32'h8080);
        @(posedge clk);
        wake <= 1'b1;
        cyc(2);
        @(posedge clk);
        wake <= 1'b0;
        cyc(1);
        chkW({30'h0, powerState}, 32'h0);
        bus(1'b1, 4'h4, 32'h0014);
        bus(1'b1, 4'h0, 32'h0177);
        rdChk(4'h4, 32'h0080);
        @(posedge clk);
        sleepCond <= 1'b1;
        cyc(2);
        chkW({30'h0, powerState}, 32'h1);
        @(posedge clk);
        lowLoad <= 1'b1;
        cyc(2);
        @(posedge clk);
        lowLoad <= 1'b0;
        sleepCond <= 1'b0;
        cyc(1);
        chkW({30'h0, powerState}, 32'h2);
        @(posedge clk);
        wake <= 1'b1;
        cyc(2);
        @(posedge clk);
        wake <= 1'b0;
        cyc(1);
        for (int i = 0; i < 12; i++) begin
            rnd = $urandom();
            bus(1'b1, 4'h0, rnd);
            rdChk(4'h0, rnd & 32'h8f7f);
            chkW({23'h0, feat}, {rnd[15], rnd[11:8], rnd[6:4], rnd[0]});
            bus(1'b1, 4'h8, 32'h2);
            chkW({30'h0, powerState}, 32'h0);
        end
        @(posedge clk);
        reset <= 1'b1;
        cyc(2);
        chkP(pin, spc_pkg::PIN_HIZ);
        @(posedge clk);
        reset <= 1'b0;
        rdChk(4'h0, 32'h0177);
        results();
    end
endmodule : tb_spc_shutdown_pin
